//--- core/rsos_pkg.sv
`default_nettype none
package rsos_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timebase
  localparam int unsigned CLK_HZ = 10_000_000; // mclk rate
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000; // cycles per millisecond
  localparam int unsigned CNT_W = 24; // width of every delay counter

  // supervisor times, in ms
  localparam int unsigned REC_MS = 250; // nominal recovery after supply returns
  localparam int unsigned REC_MAX_MS = 300; // longest recovery allowed
  localparam int unsigned DEB_MS = 250; // pushbutton debounce hold
  localparam int unsigned PULSE_MS = 250; // reset pulse after button release
  localparam int unsigned HALT_MS = 100; // continuous stop before halt flag

  // derived cycle counts
  localparam int unsigned REC_CYC = REC_MS * CYC_PER_MS;
  localparam int unsigned REC_MAX_CYC = REC_MAX_MS * CYC_PER_MS;
  localparam int unsigned DEB_CYC = DEB_MS * CYC_PER_MS;
  localparam int unsigned PULSE_CYC = PULSE_MS * CYC_PER_MS;
  localparam int unsigned HALT_CYC = HALT_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_CYC = 4; // pin pull-up plus synchroniser delay

  // half periods of the output waves, in cycles
  localparam int unsigned SQW_1HZ_HALF = CLK_HZ / 2;
  localparam int unsigned SQW_1K_HALF = CLK_HZ / (2 * 1024);
  localparam int unsigned SQW_4K_HALF = CLK_HZ / (2 * 4096);
  localparam int unsigned SQW_8K_HALF = CLK_HZ / (2 * 8192);
  localparam int unsigned FIX32_HALF = CLK_HZ / (2 * 32768);

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h0E; // control
  localparam logic [7:0] STAT_IDX = 8'h0F; // oscillator status and clock enable
  localparam logic [7:0] IRQ_STAT_IDX = 8'h10; // sticky event bits
  localparam logic [7:0] IRQ_MASK_IDX = 8'h11; // event enables

  // control bit positions
  localparam int unsigned CTRL_OSC_DIS = 7; // osc_disable_n, 1 stops the oscillator
  localparam int unsigned CTRL_RS_HI = 4; // rate_select_hi
  localparam int unsigned CTRL_RS_LO = 3; // rate_select_lo
  localparam int unsigned CTRL_MODE = 2; // irq_mode_select
  localparam int unsigned CTRL_A2EN = 1; // alarm 2 enable
  localparam int unsigned CTRL_A1EN = 0; // alarm 1 enable
  localparam logic [7:0] CTRL_RST = 8'h1C; // interrupt mode, fastest rate, alarms off

  // status bit positions
  localparam int unsigned STAT_HALT = 7; // osc_halt_flag
  localparam int unsigned STAT_EN32 = 3; // fixed_rate_clock_out enable
  localparam logic [7:0] STAT_RST = 8'h88;

  // event bit positions
  localparam int unsigned EV_PF = 0; // supply fell below threshold
  localparam int unsigned EV_PB = 1; // pushbutton press accepted
  localparam int unsigned EV_HALT = 2; // halt flag set
  localparam int unsigned EV_REL = 3; // reset released after supply return
  localparam int unsigned EV_W = 4;

  // supervisor states
  typedef enum logic [2:0] {ST_IDLE, ST_PF, ST_REC, ST_DEB, ST_WAIT, ST_PULSE} rsos_state_t;

  // last cycle of a count of lim cycles
  function automatic logic cnt_done(input logic [CNT_W-1:0] c, input int unsigned lim);
    return c == CNT_W'(lim - 1);
  endfunction : cnt_done

  // byte address of a register index
  function automatic logic [7:0] reg_byte(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : reg_byte

endpackage : rsos_pkg
`default_nettype wire

//--- core/rsos_supervisor.sv
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - reset line low while supply below threshold
// - hold reset low for recovery delay
// - oscillator disabled: release reset at once
// - reset line never stops other logic
// - reset pin is output and pushbutton input
// - debounce, wait release, then reset pulse
// - mode 0: square wave at selected rate
// - mode 1: enabled alarm match asserts pin
// - mode bit resets to interrupt mode
// - set halt flag after continuous stop
// - halt-detect delay is 100 ms
// - fixed-rate clock runs on either supply
module rsos_supervisor #(
  parameter int unsigned REC_CYC = rsos_pkg::REC_CYC, // recovery delay, cycles
  parameter int unsigned DEB_CYC = rsos_pkg::DEB_CYC, // debounce hold, cycles
  parameter int unsigned PULSE_CYC = rsos_pkg::PULSE_CYC, // reset pulse, cycles
  parameter int unsigned HALT_CYC = rsos_pkg::HALT_CYC, // halt-detect delay, cycles
  parameter int unsigned SQW_1HZ_HALF = rsos_pkg::SQW_1HZ_HALF, // 1 Hz half period
  parameter int unsigned SQW_1K_HALF = rsos_pkg::SQW_1K_HALF // 1.024 kHz half period
) (
  input wire logic mclk, // 10 MHz timebase
  input wire logic resetn, // synchronous, active low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after reg_rd
  input wire logic vcc_ok_pin, // supply above powerfail_threshold, async
  input wire logic osc_running_pin, // oscillator running, async
  input wire logic rst_line_in, // level on the reset pin
  output logic rst_line_out, // reset pin drive value, always low
  output logic rst_line_oe, // high while pulling the reset pin low
  input wire logic alarm1_match, // alarm 1 compare hit, same clock
  input wire logic alarm2_match, // alarm 2 compare hit, same clock
  output logic irq_or_wave_out_n, // multifunction pin drive value, always low
  output logic irq_or_wave_oe, // high while pulling the multifunction pin low
  output logic fixed_rate_clock_out, // fixed clock pin drive value, always low
  output logic fixed_rate_clock_oe, // high while pulling the fixed clock pin low
  output logic irq // level interrupt to software
);

  localparam int unsigned W = rsos_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: vcc, oscillator, reset pin
  logic [2:0] sync1_q; // first stage, read only by sync2_q
  logic [2:0] sync2_q; // settled levels
  logic line_prev_q; // reset pin one cycle older, for edges
  logic vcc_s;
  logic osc_s;
  logic line_s;

  // two flip-flops before anything looks at a pin
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      // reset line starts low: the reset state pulls it, and a high start would read as a press
      sync1_q <= 3'h3;
      sync2_q <= 3'h3;
      line_prev_q <= 1'b0;
    end else begin
      sync1_q <= {rst_line_in, osc_running_pin, vcc_ok_pin};
      sync2_q <= sync1_q;
      line_prev_q <= sync2_q[2];
    end
  end

  assign vcc_s = sync2_q[0];
  assign osc_s = sync2_q[1];
  assign line_s = sync2_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  logic [7:0] ctrl_q; // control
  logic [7:0] ctrl_d;
  logic halt_q; // osc_halt_flag
  logic halt_d;
  logic en32_q; // fixed clock enable
  logic en32_d;
  logic [rsos_pkg::EV_W-1:0] ev_q; // sticky events
  logic [rsos_pkg::EV_W-1:0] ev_d;
  logic [rsos_pkg::EV_W-1:0] mask_q; // event enables
  logic [rsos_pkg::EV_W-1:0] mask_d;
  logic [7:0] rdata_q; // read data
  logic [7:0] rdata_d;
  logic [rsos_pkg::EV_W-1:0] ev_now; // events of this cycle
  logic halt_set; // halt detected this cycle

  // write decode, read mux, sticky bits; a set beats a clear in the same cycle
  always_comb begin
    ctrl_d = ctrl_q;
    halt_d = halt_q;
    en32_d = en32_q;
    mask_d = mask_q;
    ev_d = ev_q;
    rdata_d = 8'h00;
    if (reg_wr) begin
      if (reg_addr == rsos_pkg::reg_byte(rsos_pkg::CTRL_IDX)) begin
        ctrl_d = reg_wdata;
      end
      if (reg_addr == rsos_pkg::reg_byte(rsos_pkg::STAT_IDX)) begin
        en32_d = reg_wdata[rsos_pkg::STAT_EN32];
        // halt flag clears by writing zero to it
        if (!reg_wdata[rsos_pkg::STAT_HALT]) begin
          halt_d = 1'b0;
        end
      end
      if (reg_addr == rsos_pkg::reg_byte(rsos_pkg::IRQ_STAT_IDX)) begin
        ev_d = ev_q & ~reg_wdata[rsos_pkg::EV_W-1:0];
      end
      if (reg_addr == rsos_pkg::reg_byte(rsos_pkg::IRQ_MASK_IDX)) begin
        mask_d = reg_wdata[rsos_pkg::EV_W-1:0];
      end
    end
    if (halt_set) begin
      halt_d = 1'b1;
    end
    ev_d = ev_d | ev_now;
    if (reg_rd) begin
      case (reg_addr)
        rsos_pkg::reg_byte(rsos_pkg::CTRL_IDX): rdata_d = ctrl_q;
        rsos_pkg::reg_byte(rsos_pkg::STAT_IDX): begin
          rdata_d[rsos_pkg::STAT_HALT] = halt_q;
          rdata_d[rsos_pkg::STAT_EN32] = en32_q;
        end
        rsos_pkg::reg_byte(rsos_pkg::IRQ_STAT_IDX): rdata_d = {4'h0, ev_q};
        rsos_pkg::reg_byte(rsos_pkg::IRQ_MASK_IDX): rdata_d = {4'h0, mask_q};
        default: rdata_d = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // register stage
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_q <= rsos_pkg::CTRL_RST;
      halt_q <= rsos_pkg::STAT_RST[rsos_pkg::STAT_HALT];
      en32_q <= rsos_pkg::STAT_RST[rsos_pkg::STAT_EN32];
      ev_q <= '0;
      mask_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      halt_q <= halt_d;
      en32_q <= en32_d;
      ev_q <= ev_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = |(ev_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // reset supervisor: power fail, recovery, pushbutton
  rsos_pkg::rsos_state_t st_q; // supervisor state
  rsos_pkg::rsos_state_t st_d;
  logic [W-1:0] cnt_q; // delay counter, shared by all timed states
  logic [W-1:0] cnt_d;
  logic ev_pf;
  logic ev_pb;
  logic ev_rel;

  // power fail overrides every pushbutton phase
  always_comb begin
    st_d = st_q;
    cnt_d = W'(cnt_q + 1'b1);
    ev_pf = 1'b0;
    ev_pb = 1'b0;
    ev_rel = 1'b0;
    if (!vcc_s) begin
      st_d = rsos_pkg::ST_PF;
      cnt_d = '0;
      ev_pf = (st_q != rsos_pkg::ST_PF);
    end else begin
      case (st_q)
        rsos_pkg::ST_PF: begin
          cnt_d = '0;
          // no running oscillator means nothing to wait for
          if (ctrl_q[rsos_pkg::CTRL_OSC_DIS] || !osc_s) begin
            st_d = rsos_pkg::ST_IDLE;
            ev_rel = 1'b1;
          end else begin
            st_d = rsos_pkg::ST_REC;
          end
        end
        rsos_pkg::ST_REC: begin
          if (rsos_pkg::cnt_done(cnt_q, REC_CYC)) begin
            st_d = rsos_pkg::ST_IDLE;
            ev_rel = 1'b1;
          end
        end
        rsos_pkg::ST_IDLE: begin
          cnt_d = '0;
          // a falling edge that the block did not cause is a button press
          if (line_prev_q && !line_s) begin
            st_d = rsos_pkg::ST_DEB;
            ev_pb = 1'b1;
          end
        end
        rsos_pkg::ST_DEB: begin
          if (rsos_pkg::cnt_done(cnt_q, DEB_CYC)) begin
            st_d = rsos_pkg::ST_WAIT;
            cnt_d = '0;
          end
        end
        rsos_pkg::ST_WAIT: begin
          // let our own drive fade through the synchroniser first
          if (cnt_q >= W'(rsos_pkg::SETTLE_CYC)) begin
            cnt_d = cnt_q;
            if (line_s) begin
              // already high at the first look: button let go during debounce
              st_d = line_prev_q ? rsos_pkg::ST_IDLE : rsos_pkg::ST_PULSE;
              cnt_d = '0;
            end
          end
        end
        rsos_pkg::ST_PULSE: begin
          if (rsos_pkg::cnt_done(cnt_q, PULSE_CYC)) begin
            st_d = rsos_pkg::ST_IDLE;
            cnt_d = '0;
          end
        end
        default: begin
          st_d = rsos_pkg::ST_IDLE;
          cnt_d = '0;
        end
      endcase
    end
  end

  // register stage
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= rsos_pkg::ST_PF;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // the pin is driven in every state but idle and the release wait;
  // nothing else in the block looks at it, so timekeeping runs on
  assign rst_line_oe = (st_q != rsos_pkg::ST_IDLE) && (st_q != rsos_pkg::ST_WAIT);
  assign rst_line_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator halt detect
  logic [W-1:0] osc_cnt_q; // cycles of continuous stop
  logic [W-1:0] osc_cnt_d;

  // any running sample restarts the count
  always_comb begin
    osc_cnt_d = '0;
    halt_set = 1'b0;
    if (!osc_s) begin
      if (rsos_pkg::cnt_done(osc_cnt_q, HALT_CYC)) begin
        osc_cnt_d = osc_cnt_q;
        halt_set = 1'b1;
      end else begin
        osc_cnt_d = W'(osc_cnt_q + 1'b1);
      end
    end
  end

  // register stage
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      osc_cnt_q <= '0;
    end else begin
      osc_cnt_q <= osc_cnt_d;
    end
  end

  assign ev_now = {ev_rel, halt_set & ~halt_q, ev_pb, ev_pf};

  ////////////////////////////////////////////////////////////////////////////
  // multifunction pin and fixed-rate clock
  logic [W-1:0] sqw_half; // half period for the chosen rate
  logic sqw_level;
  logic fix_level;
  logic alarm_hit;
  logic wave_oe_q; // multifunction pin drive
  logic wave_oe_d;

  // rate select
  always_comb begin
    case ({ctrl_q[rsos_pkg::CTRL_RS_HI], ctrl_q[rsos_pkg::CTRL_RS_LO]})
      2'b00: sqw_half = W'(SQW_1HZ_HALF);
      2'b01: sqw_half = W'(SQW_1K_HALF);
      2'b10: sqw_half = W'(rsos_pkg::SQW_4K_HALF);
      default: sqw_half = W'(rsos_pkg::SQW_8K_HALF);
    endcase
  end

  rsos_toggle_div #(.CNT_W(W)) u_sqw (
    .mclk(mclk),
    .resetn(resetn),
    .en(!ctrl_q[rsos_pkg::CTRL_MODE]),
    .half_cnt(sqw_half),
    .level_q(sqw_level)
  );

  // free of any supply condition: battery operation keeps it running
  rsos_toggle_div #(.CNT_W(W)) u_fix (
    .mclk(mclk),
    .resetn(resetn),
    .en(en32_q),
    .half_cnt(W'(rsos_pkg::FIX32_HALF)),
    .level_q(fix_level)
  );

  // only enabled alarms reach the pin
  always_comb begin
    alarm_hit = (alarm1_match && ctrl_q[rsos_pkg::CTRL_A1EN]) ||
                (alarm2_match && ctrl_q[rsos_pkg::CTRL_A2EN]);
    if (ctrl_q[rsos_pkg::CTRL_MODE]) begin
      wave_oe_d = alarm_hit;
    end else begin
      wave_oe_d = !sqw_level;
    end
  end

  // register stage
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wave_oe_q <= 1'b0;
    end else begin
      wave_oe_q <= wave_oe_d;
    end
  end

  assign irq_or_wave_out_n = 1'b0;
  assign irq_or_wave_oe = wave_oe_q;
  assign fixed_rate_clock_out = 1'b0;
  assign fixed_rate_clock_oe = en32_q && !fix_level;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_pf_drive;
    !vcc_s |=> rst_line_oe && (st_q == rsos_pkg::ST_PF);
  endproperty
  a_pf_drive: assert property (p_pf_drive) else $error("reset line not driven in power fail");

  property p_rec_hold;
    (st_q == rsos_pkg::ST_REC) && vcc_s && !rsos_pkg::cnt_done(cnt_q, REC_CYC) |=>
      (st_q == rsos_pkg::ST_REC) && rst_line_oe && (cnt_q == W'($past(cnt_q) + 1'b1));
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("recovery hold ended early");

  property p_rec_end;
    (st_q == rsos_pkg::ST_REC) && vcc_s && rsos_pkg::cnt_done(cnt_q, REC_CYC) |=>
      !rst_line_oe && ev_q[rsos_pkg::EV_REL];
  endproperty
  a_rec_end: assert property (p_rec_end) else $error("reset not released after recovery");

  property p_bypass;
    (st_q == rsos_pkg::ST_PF) && vcc_s && ctrl_q[rsos_pkg::CTRL_OSC_DIS] |=>
      (st_q == rsos_pkg::ST_IDLE) && !rst_line_oe;
  endproperty
  a_bypass: assert property (p_bypass) else $error("recovery not bypassed");

  property p_press;
    (st_q == rsos_pkg::ST_IDLE) && vcc_s && $fell(line_s) |=>
      rst_line_oe && ev_q[rsos_pkg::EV_PB];
  endproperty
  a_press: assert property (p_press) else $error("button press not taken");

  property p_release;
    (st_q == rsos_pkg::ST_WAIT) && vcc_s && (cnt_q >= W'(rsos_pkg::SETTLE_CYC)) && $rose(line_s) |=>
      rst_line_oe ##1 rst_line_oe;
  endproperty
  a_release: assert property (p_release) else $error("no reset pulse after release");

  property p_wave;
    !ctrl_q[rsos_pkg::CTRL_MODE] && $changed(sqw_level) |-> ##1 (irq_or_wave_oe == !$past(sqw_level));
  endproperty
  a_wave: assert property (p_wave) else $error("square wave not on pin");

  property p_alarm;
    ctrl_q[rsos_pkg::CTRL_MODE] && $stable(ctrl_q) |=> (irq_or_wave_oe == $past(alarm_hit));
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm output wrong");

  property p_mode_reset;
    $rose(resetn) |-> ctrl_q[rsos_pkg::CTRL_MODE] && !ctrl_q[rsos_pkg::CTRL_A1EN] && !ctrl_q[rsos_pkg::CTRL_A2EN];
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("control not at default");

  property p_halt;
    !osc_s && rsos_pkg::cnt_done(osc_cnt_q, HALT_CYC) |=> halt_q;
  endproperty
  a_halt: assert property (p_halt) else $error("halt flag not set");

  property p_halt_early;
    osc_s |=> (osc_cnt_q == '0);
  endproperty
  a_halt_early: assert property (p_halt_early) else $error("halt count not restarted");

  property p_fix_run;
    en32_q && $rose(fix_level) |-> ##[1:400] ($fell(fix_level) || !en32_q);
  endproperty
  a_fix_run: assert property (p_fix_run) else $error("fixed clock stalled");

endmodule : rsos_supervisor
`default_nettype wire

//--- core/rsos_toggle_div.sv
`timescale 1ns/1ps
`default_nettype none
module rsos_toggle_div #(
  parameter int unsigned CNT_W = 24 // counter width
) (
  input wire logic mclk, // block clock
  input wire logic resetn, // synchronous, active low
  input wire logic en, // run; low parks the wave low
  input wire logic [CNT_W-1:0] half_cnt, // cycles per half period
  output logic level_q // wave output, from a flip-flop
);

  logic [CNT_W-1:0] cnt_q; // cycles into this half period
  logic [CNT_W-1:0] cnt_d;
  logic level_d;

  ////////////////////////////////////////////////////////////////////////////
  // next values: toggle at the end of every half period
  always_comb begin
    cnt_d = CNT_W'(cnt_q + 1'b1);
    level_d = level_q;
    if (!en) begin
      // parked low, so a re-enable starts with a full half period
      cnt_d = '0;
      level_d = 1'b0;
    end else if (cnt_q >= CNT_W'(half_cnt - 1'b1)) begin
      // >= rather than == so a shorter rate chosen mid-period cannot run away
      cnt_d = '0;
      level_d = ~level_q;
    end
  end

  // registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      level_q <= level_d;
    end
  end

endmodule : rsos_toggle_div
`default_nettype wire

//--- tb/rsos_host_side.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// host reset input and pushbutton, sharing the open-drain reset line
module rsos_host_side (
  input wire logic rst_line_oe, // device pulls the line low
  input wire logic press, // button closed, shorts the line to ground
  output logic rst_line_in, // resolved line level
  output logic host_in_reset // host reset input, active while the line is low
);
  // wired-and with a pull-up: nobody drives high, so a released line floats up
  assign rst_line_in = !(rst_line_oe || press);
  // the host only sees the line, not who pulls it
  assign host_in_reset = !rst_line_in;
endmodule : rsos_host_side
`default_nettype wire

//--- tb/rsos_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rsos_supervisor_tb_top;
  // scaled delays keep the run short; expectations follow them
  localparam int unsigned REC = 20; // recovery cycles
  localparam int unsigned DEB = 20; // debounce cycles
  localparam int unsigned PUL = 20; // reset pulse cycles
  localparam int unsigned HLT = 10; // halt-detect cycles
  localparam logic [7:0] A_CTRL = 8'h38; // control
  localparam logic [7:0] A_STAT = 8'h3C; // status
  localparam logic [7:0] A_IST = 8'h40; // event bits
  localparam logic [7:0] A_MSK = 8'h44; // event mask
  logic mclk = 1'b0; // 10 MHz
  logic resetn = 1'b0; // held low at start
  logic [7:0] reg_addr = 8'h00; // bus address
  logic [7:0] reg_wdata = 8'h00; // bus write data
  logic reg_wr = 1'b0; // write strobe
  logic reg_rd = 1'b0; // read strobe
  logic vcc_ok = 1'b1; // supply above threshold
  logic osc_run = 1'b1; // oscillator running
  logic press = 1'b0; // button
  logic alarm1 = 1'b0; // alarm 1 hit
  logic alarm2 = 1'b0; // alarm 2 hit
  logic [7:0] reg_rdata; // read data
  logic rst_in, rst_oe, wave_oe, fix_oe, irq, host_rst; // observed pins
  logic [2:0] od_out; // open-drain drive values, always low
  int n_mismatch = 0; // mismatches
  int tests_run = 0; // comparisons
  always #50 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  rsos_supervisor #(.REC_CYC(REC), .DEB_CYC(DEB), .PULSE_CYC(PUL), .HALT_CYC(HLT),
    .SQW_1HZ_HALF(50), .SQW_1K_HALF(8)) dut_u (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vcc_ok_pin(vcc_ok),
    .osc_running_pin(osc_run), .rst_line_in(rst_in), .rst_line_out(od_out[0]), .rst_line_oe(rst_oe),
    .alarm1_match(alarm1), .alarm2_match(alarm2), .irq_or_wave_out_n(od_out[1]), .irq_or_wave_oe(wave_oe),
    .fixed_rate_clock_out(od_out[2]), .fixed_rate_clock_oe(fix_oe), .irq(irq));
  rsos_host_side host_u (.rst_line_oe(rst_oe), .press(press), .rst_line_in(rst_in),
    .host_in_reset(host_rst));
  ////////////////////////////////////////////////////////////////////////////
  // settle past the edge so every update has landed
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rchk
  // second change-to-change gap; the first may be partial
  task automatic meas(input bit fx, output int n);
    logic s;
    repeat (2) begin
      s = fx ? fix_oe : wave_oe;
      n = 0;
      while ((fx ? fix_oe : wave_oe) === s && n < 3000) begin
        cyc(1);
        n++;
      end
    end
  endtask : meas
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rchk(A_CTRL, 8'h1C);
    rchk(A_STAT, 8'h88);
    rchk(8'h20, 8'h00);
    chk(16'(od_out), 16'h0000);
  endtask : t_regs
  task automatic t_power;
    wr(A_IST, 8'h0F);
    wr(A_MSK, 8'h09);
    @(posedge mclk) vcc_ok <= 1'b0;
    cyc(4);
    chk(rst_oe, 1'b1);
    chk(host_rst, 1'b1);
    rchk(A_CTRL, 8'h1C);
    @(posedge mclk) vcc_ok <= 1'b1;
    cyc(REC);
    chk(rst_oe, 1'b1);
    cyc(8);
    chk(rst_oe, 1'b0);
    rchk(A_IST, 8'h09);
    chk(irq, 1'b1);
    wr(A_IST, 8'h09);
    chk(irq, 1'b0);
  endtask : t_power
  task automatic t_bypass;
    wr(A_CTRL, 8'h9C);
    @(posedge mclk) vcc_ok <= 1'b0;
    cyc(6);
    @(posedge mclk) vcc_ok <= 1'b1;
    cyc(5);
    chk(rst_oe, 1'b0);
    wr(A_CTRL, 8'h1C);
    // a stopped oscillator skips the recovery as well
    @(posedge mclk) osc_run <= 1'b0;
    vcc_ok <= 1'b0;
    cyc(6);
    @(posedge mclk) vcc_ok <= 1'b1;
    cyc(5);
    chk(rst_oe, 1'b0);
    @(posedge mclk) osc_run <= 1'b1;
  endtask : t_bypass
  task automatic t_press;
    wr(A_IST, 8'h0F);
    @(posedge mclk) press <= 1'b1;
    cyc(5);
    chk(rst_oe, 1'b1);
    cyc(DEB + 5);
    chk(rst_oe, 1'b0);
    @(posedge mclk) press <= 1'b0;
    cyc(6);
    chk(rst_oe, 1'b1);
    cyc(PUL + 4);
    chk(rst_oe, 1'b0);
    rchk(A_IST, 8'h02);
    chk(irq, 1'b0);
    // let go inside the debounce time: no second pulse may follow
    @(posedge mclk) press <= 1'b1;
    cyc(8);
    @(posedge mclk) press <= 1'b0;
    cyc(DEB + 6);
    chk(rst_oe, 1'b0);
  endtask : t_press
  task automatic t_wave;
    int n;
    int unsigned exp [4];
    exp = '{50, 8, rsos_pkg::SQW_4K_HALF, rsos_pkg::SQW_8K_HALF};
    for (int i = 0; i < 4; i++) begin
      wr(A_CTRL, {3'b000, 2'(i), 3'b000});
      meas(1'b0, n);
      chk(16'(n), 16'(exp[i]));
    end
  endtask : t_wave
  task automatic t_alarm;
    wr(A_CTRL, 8'h05);
    @(posedge mclk) alarm1 <= 1'b1;
    cyc(2);
    chk(wave_oe, 1'b1);
    @(posedge mclk) alarm1 <= 1'b0;
    alarm2 <= 1'b1;
    cyc(2);
    chk(wave_oe, 1'b0);
    wr(A_CTRL, 8'h06);
    cyc(2);
    chk(wave_oe, 1'b1);
    @(posedge mclk) alarm2 <= 1'b0;
    cyc(2);
    chk(wave_oe, 1'b0);
  endtask : t_alarm
  task automatic t_halt;
    wr(A_STAT, 8'h08);
    wr(A_IST, 8'h0F);
    @(posedge mclk) osc_run <= 1'b0;
    cyc(HLT - 4);
    @(posedge mclk) osc_run <= 1'b1;
    cyc(4);
    rchk(A_STAT, 8'h08);
    @(posedge mclk) osc_run <= 1'b0;
    cyc(HLT + 6);
    rchk(A_STAT, 8'h88);
    rchk(A_IST, 8'h04);
    @(posedge mclk) osc_run <= 1'b1;
  endtask : t_halt
  // runs from backup as well: measure with the supply gone
  task automatic t_fixed;
    int n;
    @(posedge mclk) vcc_ok <= 1'b0;
    meas(1'b1, n);
    chk(16'(n), 16'(rsos_pkg::FIX32_HALF));
    @(posedge mclk) vcc_ok <= 1'b1;
    cyc(REC + 10);
    // disabled: the pin stays released, so meas runs out at its limit
    wr(A_STAT, 8'h80);
    meas(1'b1, n);
    chk(16'(n), 16'h0bb8);
  endtask : t_fixed
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // whole sequence is near 10k cycles; six times that means a hang
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    cyc(REC + 10);
    t_regs();
    t_power();
    t_bypass();
    t_press();
    t_wave();
    t_alarm();
    t_halt();
    t_fixed();
    summarize();
  end
endmodule : rsos_supervisor_tb_top
`default_nettype wire
